// >>> rtl/lrc_receiver_ctrl.sv
`timescale 1ns/1ps
// Function
// - enable starts power-up at next oscillator edge
// - bit 7 enable: standby or active, read-write
// - bit 6 starts soft reset, self-clears, reads zero
// - bit 5 selects data or carrier mode
// - bits 3:2 select wake-up id scheme
// - bits 1:0 set detect and no-detect thresholds
// - sensitivity only affects carrier-detect path
// - sensitivity codes rise very low to very high
// - power-on and soft reset clear fields
// - carrier mode sets flag, interrupt if enabled
// - message accepted only on id match
module lrc_receiver_ctrl
  import lrc_pkg::*;
#(
  parameter int AZ_CYCLES = LRC_AUTOZERO_CYCLES,
  parameter int SRST_CYCLES = LRC_SOFT_RESET_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receiver front end
  input wire logic lfoClk,
  input wire logic [7:0] signalLevel,
  input wire logic rxIdValid,
  input wire logic [15:0] rxId,
  // receiver status
  output logic receiverActive,
  output logic receiverPowering,
  output logic receiverAutoZero,
  output logic receiverReady,
  output logic carrierPresent,
  output logic msgAccepted,
  output logic irq
);
  lrc_seq_if sqIf();

  logic ctrlEnable, next_ctrlEnable;
  logic ctrlMode, next_ctrlMode;
  logic [1:0] ctrlIdSel, next_ctrlIdSel;
  logic [1:0] ctrlSens, next_ctrlSens;
  logic [3:0] srstCount, next_srstCount;
  logic [7:0] idLow, next_idLow;
  logic [7:0] idHigh, next_idHigh;
  logic [LRC_NUM_EVT-1:0] status, next_status;
  logic [LRC_NUM_EVT-1:0] mask, next_mask;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic lfoPrev;
  logic next_carrierPresent;
  logic next_msgAccepted;
  logic next_irq;
  logic wrAccess, rdSetup, srstBusy;
  logic [LRC_NUM_EVT-1:0] evtSet;
  logic [7:0] ctrlRead;

  function automatic logic [7:0] detLevel(input logic [1:0] detect_sensitivity);
    case (detect_sensitivity)
      LRC_DETECT_SENSITIVITY_VLOW: detLevel = LRC_DET_VL;
      LRC_DETECT_SENSITIVITY_LOW: detLevel = LRC_DET_L;
      LRC_DETECT_SENSITIVITY_HIGH: detLevel = LRC_DET_H;
      default: detLevel = LRC_DET_VH;
    endcase
  endfunction

  function automatic logic [7:0] noDetLevel(input logic [1:0] detect_sensitivity);
    case (detect_sensitivity)
      LRC_DETECT_SENSITIVITY_VLOW: noDetLevel = LRC_NODET_VL;
      LRC_DETECT_SENSITIVITY_LOW: noDetLevel = LRC_NODET_L;
      LRC_DETECT_SENSITIVITY_HIGH: noDetLevel = LRC_NODET_H;
      default: noDetLevel = LRC_NODET_VH;
    endcase
  endfunction

  function automatic logic idMatch(input logic [1:0] sel, input logic [15:0] rx,
                                   input logic [7:0] lo, input logic [7:0] hi);
    case (sel)
      LRC_ID_NONE: idMatch = 1'b1;
      LRC_ID_LOW8: idMatch = (rx[7:0] == lo);
      LRC_ID_FULL16: idMatch = (rx == {hi, lo});
      default: idMatch = (rx[7:0] == lo) || (rx[7:0] == hi);
    endcase
  endfunction

  lrc_powerup_seq #(
    .AZ_CYCLES(AZ_CYCLES)
  ) uSeq (
    .clk(clk),
    .reset(reset),
    .sq(sqIf.seq)
  );

  assign sqIf.enable = ctrlEnable;
  assign sqIf.lfoRise = lfoClk & ~lfoPrev;
  assign receiverActive = ctrlEnable;
  assign receiverPowering = sqIf.powering;
  assign receiverAutoZero = sqIf.autoZeroing;
  assign receiverReady = sqIf.ready;
  assign pready = 1'b1;

  assign wrAccess = psel & penable & pwrite;
  assign rdSetup = psel & ~penable;
  assign srstBusy = (srstCount != 4'h0);

  // bit 6 and bit 4 read zero
  always_comb begin
    ctrlRead = 8'h00;
    ctrlRead[LRC_BIT_ENABLE] = ctrlEnable;
    ctrlRead[LRC_BIT_MODE] = ctrlMode;
    ctrlRead[LRC_WAKEUP_ID_SELECT_HI:LRC_WAKEUP_ID_SELECT_LO] = ctrlIdSel;
    ctrlRead[LRC_DETECT_SENSITIVITY_HI:LRC_DETECT_SENSITIVITY_LO] = ctrlSens;
  end

  // detection, id check and events
  always_comb begin
    next_carrierPresent = carrierPresent;
    next_msgAccepted = 1'b0;
    evtSet = '0;
    if (sqIf.ready && ctrlMode) begin
      // sensitivity thresholds act only here
      if (signalLevel > detLevel(ctrlSens)) begin
        next_carrierPresent = 1'b1;
      end else if (signalLevel < noDetLevel(ctrlSens)) begin
        next_carrierPresent = 1'b0;
      end
      evtSet[LRC_EVT_CARRIER] = next_carrierPresent & ~carrierPresent;
    end else begin
      next_carrierPresent = 1'b0;
    end
    if (sqIf.ready && !ctrlMode && rxIdValid) begin
      if (idMatch(ctrlIdSel, rxId, idLow, idHigh)) begin
        next_msgAccepted = 1'b1;
        evtSet[LRC_EVT_ACCEPT] = 1'b1;
      end else begin
        evtSet[LRC_EVT_MISMATCH] = 1'b1;
      end
    end
  end

  // register writes and reads
  always_comb begin
    next_ctrlEnable = ctrlEnable;
    next_ctrlMode = ctrlMode;
    next_ctrlIdSel = ctrlIdSel;
    next_ctrlSens = ctrlSens;
    next_srstCount = srstBusy ? srstCount - 4'h1 : srstCount;
    next_idLow = idLow;
    next_idHigh = idHigh;
    next_mask = mask;
    next_status = status;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (wrAccess) begin
      case (paddr)
        LRC_ADDR_CTRL1: begin
          next_ctrlEnable = pwdata[LRC_BIT_ENABLE];
          next_ctrlMode = pwdata[LRC_BIT_MODE];
          next_ctrlIdSel = pwdata[LRC_WAKEUP_ID_SELECT_HI:LRC_WAKEUP_ID_SELECT_LO];
          next_ctrlSens = pwdata[LRC_DETECT_SENSITIVITY_HI:LRC_DETECT_SENSITIVITY_LO];
          if (pwdata[LRC_BIT_SOFT_RESET]) begin
            next_srstCount = 4'(SRST_CYCLES);
          end
        end
        LRC_ADDR_STATUS: next_status = status & ~pwdata[LRC_NUM_EVT-1:0];
        LRC_ADDR_MASK: next_mask = pwdata[LRC_NUM_EVT-1:0];
        LRC_ADDR_ID_LOW: next_idLow = pwdata[7:0];
        LRC_ADDR_ID_HIGH: next_idHigh = pwdata[7:0];
        default: next_mask = mask;
      endcase
    end
    // set wins over clear
    next_status = next_status | evtSet;
    if (srstBusy || (next_srstCount != 4'h0)) begin
      next_ctrlEnable = 1'b0;
      next_ctrlMode = 1'b0;
      next_ctrlIdSel = 2'h0;
      next_ctrlSens = 2'h0;
    end
    if (rdSetup) begin
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      case (paddr)
        LRC_ADDR_CTRL1: next_prdata = {24'h000000, ctrlRead};
        LRC_ADDR_STATUS: begin
          next_prdata[LRC_NUM_EVT-1:0] = status;
          next_prdata[LRC_STAT_SRST_BUSY] = srstBusy;
          next_prdata[LRC_STAT_READY] = sqIf.ready;
        end
        LRC_ADDR_MASK: next_prdata[LRC_NUM_EVT-1:0] = mask;
        LRC_ADDR_ID_LOW: next_prdata[7:0] = idLow;
        LRC_ADDR_ID_HIGH: next_prdata[7:0] = idHigh;
        default: next_pslverr = ~pwrite;
      endcase
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrlEnable <= LRC_CTRL1_RESET[LRC_BIT_ENABLE];
      ctrlMode <= LRC_CTRL1_RESET[LRC_BIT_MODE];
      ctrlIdSel <= LRC_CTRL1_RESET[LRC_WAKEUP_ID_SELECT_HI:LRC_WAKEUP_ID_SELECT_LO];
      ctrlSens <= LRC_CTRL1_RESET[LRC_DETECT_SENSITIVITY_HI:LRC_DETECT_SENSITIVITY_LO];
      srstCount <= 4'h0;
      idLow <= 8'h00;
      idHigh <= 8'h00;
      status <= '0;
      mask <= '0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      lfoPrev <= 1'b0;
      carrierPresent <= 1'b0;
      msgAccepted <= 1'b0;
      irq <= 1'b0;
    end else begin
      ctrlEnable <= next_ctrlEnable;
      ctrlMode <= next_ctrlMode;
      ctrlIdSel <= next_ctrlIdSel;
      ctrlSens <= next_ctrlSens;
      srstCount <= next_srstCount;
      idLow <= next_idLow;
      idHigh <= next_idHigh;
      status <= next_status;
      mask <= next_mask;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      lfoPrev <= lfoClk;
      carrierPresent <= next_carrierPresent;
      msgAccepted <= next_msgAccepted;
      irq <= next_irq;
    end
  end
endmodule

// >>> rtl/lrc_pkg.sv
package lrc_pkg;
  // register byte addresses
  localparam logic [7:0] LRC_ADDR_CTRL1 = 8'h20;
  localparam logic [7:0] LRC_ADDR_STATUS = 8'h24;
  localparam logic [7:0] LRC_ADDR_MASK = 8'h28;
  localparam logic [7:0] LRC_ADDR_ID_LOW = 8'h2C;
  localparam logic [7:0] LRC_ADDR_ID_HIGH = 8'h30;
  // control one field positions
  localparam int LRC_BIT_ENABLE = 7;
  localparam int LRC_BIT_SOFT_RESET = 6;
  localparam int LRC_BIT_MODE = 5;
  localparam int LRC_WAKEUP_ID_SELECT_HI = 3;
  localparam int LRC_WAKEUP_ID_SELECT_LO = 2;
  localparam int LRC_DETECT_SENSITIVITY_HI = 1;
  localparam int LRC_DETECT_SENSITIVITY_LO = 0;
  localparam logic [7:0] LRC_CTRL1_RESET = 8'h00;
  // status and mask layout
  localparam int LRC_EVT_CARRIER = 0;
  localparam int LRC_EVT_ACCEPT = 1;
  localparam int LRC_EVT_MISMATCH = 2;
  localparam int LRC_NUM_EVT = 3;
  localparam int LRC_STAT_SRST_BUSY = 6;
  localparam int LRC_STAT_READY = 7;
  // wake-up id selections
  localparam logic [1:0] LRC_ID_NONE = 2'h0;
  localparam logic [1:0] LRC_ID_LOW8 = 2'h1;
  localparam logic [1:0] LRC_ID_FULL16 = 2'h2;
  localparam logic [1:0] LRC_ID_EITHER8 = 2'h3;
  // sensitivity codes, rising sensitivity
  localparam logic [1:0] LRC_DETECT_SENSITIVITY_VLOW = 2'h0;
  localparam logic [1:0] LRC_DETECT_SENSITIVITY_LOW = 2'h1;
  localparam logic [1:0] LRC_DETECT_SENSITIVITY_HIGH = 2'h2;
  localparam logic [1:0] LRC_DETECT_SENSITIVITY_VHIGH = 2'h3;
  // detect and no-detect thresholds per sensitivity
  localparam logic [7:0] LRC_DET_VL = 8'hC0;
  localparam logic [7:0] LRC_NODET_VL = 8'hA0;
  localparam logic [7:0] LRC_DET_L = 8'h80;
  localparam logic [7:0] LRC_NODET_L = 8'h60;
  localparam logic [7:0] LRC_DET_H = 8'h40;
  localparam logic [7:0] LRC_NODET_H = 8'h30;
  localparam logic [7:0] LRC_DET_VH = 8'h20;
  localparam logic [7:0] LRC_NODET_VH = 8'h10;
  // timing
  localparam int LRC_CLK_PERIOD_NS = 40;
  localparam int LRC_AUTOZERO_NS = 64000;
  localparam int LRC_AUTOZERO_CYCLES =
    (LRC_AUTOZERO_NS + LRC_CLK_PERIOD_NS - 1) / LRC_CLK_PERIOD_NS;
  localparam int LRC_SOFT_RESET_CYCLES = 4;
  // power-up sequencer states
  typedef enum logic [2:0] {
    LRC_ST_OFF = 3'b000,
    LRC_ST_WAIT_EDGE = 3'b001,
    LRC_ST_POWER = 3'b010,
    LRC_ST_AUTOZERO = 3'b011,
    LRC_ST_READY = 3'b100
  } lrc_state_e;
endpackage

// >>> rtl/lrc_seq_if.sv
`timescale 1ns/1ps
interface lrc_seq_if;
  logic enable;
  logic lfoRise;
  logic powering;
  logic autoZeroing;
  logic ready;
  modport ctrl (output enable, output lfoRise, input powering, input autoZeroing, input ready);
  modport seq (input enable, input lfoRise, output powering, output autoZeroing, output ready);
endinterface

// >>> rtl/lrc_powerup_seq.sv
`timescale 1ns/1ps
module lrc_powerup_seq
  import lrc_pkg::*;
#(
  parameter int AZ_CYCLES = LRC_AUTOZERO_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link to control
  lrc_seq_if.seq sq
);
  lrc_state_e state, next_state;
  logic [15:0] azCount, next_azCount;

  always_comb begin
    next_state = state;
    next_azCount = azCount;
    case (state)
      LRC_ST_OFF: begin
        if (sq.enable) begin
          next_state = LRC_ST_WAIT_EDGE;
        end
      end
      LRC_ST_WAIT_EDGE: begin
        if (sq.lfoRise) begin
          next_state = LRC_ST_POWER;
        end
      end
      LRC_ST_POWER: begin
        if (sq.lfoRise) begin
          next_state = LRC_ST_AUTOZERO;
          next_azCount = 16'h0000;
        end
      end
      LRC_ST_AUTOZERO: begin
        if (azCount == 16'(AZ_CYCLES - 1)) begin
          next_state = LRC_ST_READY;
        end else begin
          next_azCount = azCount + 16'h0001;
        end
      end
      LRC_ST_READY: begin
        next_state = LRC_ST_READY;
      end
      default: begin
        next_state = LRC_ST_OFF;
      end
    endcase
    if (!sq.enable) begin
      next_state = LRC_ST_OFF;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= LRC_ST_OFF;
      azCount <= 16'h0000;
    end else begin
      state <= next_state;
      azCount <= next_azCount;
    end
  end

  assign sq.powering = (state == LRC_ST_POWER);
  assign sq.autoZeroing = (state == LRC_ST_AUTOZERO);
  assign sq.ready = (state == LRC_ST_READY);
endmodule

// >>> dv/lrc_receiver_ctrl_sva.sv
`timescale 1ns/1ps
module lrc_receiver_ctrl_sva
  import lrc_pkg::*;
#(
  parameter int AZ_CYCLES = LRC_AUTOZERO_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // front end and status
  input wire logic lfoClk,
  input wire logic [7:0] signalLevel,
  input wire logic rxIdValid,
  input wire logic receiverActive,
  input wire logic receiverPowering,
  input wire logic receiverAutoZero,
  input wire logic receiverReady,
  input wire logic carrierPresent,
  input wire logic msgAccepted
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [15:0] azCnt;
  logic [15:0] next_azCnt;
  always_comb next_azCnt = receiverAutoZero ? azCnt + 16'h1 : 16'h0;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) azCnt <= 16'h0;
    else azCnt <= next_azCnt;
  end
  sequence s_ctrlWr;
    psel && penable && pwrite && paddr == LRC_ADDR_CTRL1;
  endsequence
  sequence s_ctrlRd;
    psel && penable && !pwrite && paddr == LRC_ADDR_CTRL1;
  endsequence
  property p_enableOn;
    s_ctrlWr ##0 (pwdata[7] && !pwdata[6]) |=> receiverActive;
  endproperty
  property p_enableOff;
    s_ctrlWr ##0 !pwdata[7] |=> !receiverActive ##1 (!receiverPowering && !receiverReady);
  endproperty
  property p_softReset;
    s_ctrlWr ##0 pwdata[6] |=> !receiverActive [*4];
  endproperty
  property p_readZero;
    s_ctrlRd |-> prdata[6] == 1'b0 && prdata[4] == 1'b0 && prdata[7] == receiverActive;
  endproperty
  property p_powerStart;
    $rose(receiverPowering) |-> $past(lfoClk) && !$past(lfoClk, 2);
  endproperty
  property p_powerEnd;
    $fell(receiverPowering) && receiverActive |-> receiverAutoZero;
  endproperty
  property p_azLen;
    $fell(receiverAutoZero) && receiverActive |-> azCnt == AZ_CYCLES && receiverReady;
  endproperty
  property p_carrier;
    $rose(carrierPresent) |-> $past(signalLevel) > LRC_DET_VH && $past(receiverReady);
  endproperty
  property p_accept;
    msgAccepted |-> $past(rxIdValid) ##1 !msgAccepted;
  endproperty
  a_enableOn: assert property (p_enableOn) else $error("enable not set");
  a_enableOff: assert property (p_enableOff) else $error("receiver not off");
  a_softReset: assert property (p_softReset) else $error("soft reset kept enable");
  a_readZero: assert property (p_readZero) else $error("control readback wrong");
  a_powerStart: assert property (p_powerStart) else $error("power-up off edge");
  a_powerEnd: assert property (p_powerEnd) else $error("no auto-zero after power");
  a_azLen: assert property (p_azLen) else $error("auto-zero length wrong");
  a_carrier: assert property (p_carrier) else $error("carrier below threshold");
  a_accept: assert property (p_accept) else $error("accept without id");
endmodule
bind lrc_receiver_ctrl lrc_receiver_ctrl_sva #(.AZ_CYCLES(AZ_CYCLES)) i_lrc_receiver_ctrl_sva (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .lfoClk(lfoClk), .signalLevel(signalLevel),
  .rxIdValid(rxIdValid), .receiverActive(receiverActive), .receiverPowering(receiverPowering),
  .receiverAutoZero(receiverAutoZero), .receiverReady(receiverReady),
  .carrierPresent(carrierPresent), .msgAccepted(msgAccepted));

// >>> dv/test_lrc_receiver_ctrl.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin numErrors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module test_lrc_receiver_ctrl
  import lrc_pkg::*;
;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, lfoClk = 0, rxIdValid = 0;
  logic [7:0] paddr = 0, signalLevel = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [15:0] rxId = 0;
  logic [2:0] lfoDiv = 0;
  logic pready, pslverr, lastErr, receiverActive, receiverPowering, receiverAutoZero;
  logic receiverReady, carrierPresent, msgAccepted, irq;
  int numErrors = 0, checked = 0;
  wire [2:0] st = {receiverReady, receiverAutoZero, receiverPowering};
  logic [7:0] det [4] = '{LRC_DET_VL, LRC_DET_L, LRC_DET_H, LRC_DET_VH};
  logic [7:0] nodet [4] = '{LRC_NODET_VL, LRC_NODET_L, LRC_NODET_H, LRC_NODET_VH};
  always #20 clk = ~clk;
  always @(posedge clk) begin
    lfoDiv <= lfoDiv + 3'h1;
    lfoClk <= lfoDiv[2];
  end
  lrc_receiver_ctrl #(.AZ_CYCLES(8), .SRST_CYCLES(4)) i_lrc_receiver_ctrl (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lfoClk(lfoClk),
    .signalLevel(signalLevel), .rxIdValid(rxIdValid), .rxId(rxId),
    .receiverActive(receiverActive), .receiverPowering(receiverPowering),
    .receiverAutoZero(receiverAutoZero), .receiverReady(receiverReady),
    .carrierPresent(carrierPresent), .msgAccepted(msgAccepted), .irq(irq));
  task automatic finish_test;
    $display("checks %0d errors %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin numErrors++; finish_test(); end
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic waitSig(input int i, input logic v);
    int n;
    n = 0;
    while (st[i] !== v && n < 200) begin @(posedge clk); n++; end
    if (n >= 200) begin numErrors++; finish_test(); end
  endtask
  task automatic t_regs;
    logic [31:0] r;
    apb(0, LRC_ADDR_CTRL1, 0, r); `CHK(r, 32'h0)
    apb(1, LRC_ADDR_CTRL1, 32'h3F, r);
    apb(0, LRC_ADDR_CTRL1, 0, r); `CHK(r, 32'h2F)
    apb(1, LRC_ADDR_CTRL1, 32'hFF, r);
    apb(0, LRC_ADDR_STATUS, 0, r); `CHK(r[6], 1'b1)
    repeat (8) @(posedge clk);
    apb(0, LRC_ADDR_CTRL1, 0, r); `CHK(r, 32'h0)
    apb(0, 8'h40, 0, r); `CHK(lastErr, 1'b1)
    $display("regs done");
  endtask
  task automatic t_power;
    logic [31:0] r;
    int n;
    apb(1, LRC_ADDR_MASK, 32'h1, r);
    apb(1, LRC_ADDR_CTRL1, 32'hA0, r);
    waitSig(0, 1'b1);
    waitSig(1, 1'b1);
    n = 0;
    while (receiverAutoZero === 1'b1 && n < 100) begin @(posedge clk); n++; end
    `CHK(n, 8)
    `CHK(receiverReady, 1'b1)
    apb(0, LRC_ADDR_STATUS, 0, r); `CHK(r[7], 1'b1)
    $display("power done");
  endtask
  task automatic t_carrier;
    logic [31:0] r;
    for (int s = 0; s < 4; s++) begin
      apb(1, LRC_ADDR_CTRL1, 32'hA0 | s, r);
      signalLevel <= nodet[s] - 8'h1;
      repeat (3) @(posedge clk);
      `CHK(carrierPresent, 1'b0)
      signalLevel <= det[s] + 8'h1;
      repeat (3) @(posedge clk);
      `CHK(carrierPresent, 1'b1)
      `CHK(irq, 1'b1)
      signalLevel <= nodet[s] + 8'h1;
      apb(1, LRC_ADDR_STATUS, 32'h1, r);
      `CHK(carrierPresent, 1'b1)
      `CHK(irq, 1'b0)
    end
    apb(1, LRC_ADDR_MASK, 0, r);
    signalLevel <= 8'h00;
    repeat (3) @(posedge clk);
    signalLevel <= 8'hFF;
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    apb(0, LRC_ADDR_STATUS, 0, r); `CHK(r[0], 1'b1)
    $display("carrier done");
  endtask
  task automatic t_id;
    logic [31:0] r;
    logic seen;
    logic [15:0] ids [8] = '{16'h1234, 16'h0000, 16'h005A, 16'h00C3,
                             16'hC35A, 16'h005A, 16'h00C3, 16'h0011};
    logic [7:0] acc = 8'b0101_0111;
    apb(1, LRC_ADDR_ID_LOW, 32'h5A, r);
    apb(1, LRC_ADDR_ID_HIGH, 32'hC3, r);
    for (int i = 0; i < 8; i++) begin
      if (i % 2 == 0) apb(1, LRC_ADDR_CTRL1, 32'h80 | ((i / 2) << 2) | (i / 2), r);
      rxId <= ids[i];
      rxIdValid <= 1'b1;
      @(posedge clk);
      rxIdValid <= 1'b0;
      seen = 1'b0;
      repeat (3) begin @(posedge clk); seen = seen | msgAccepted; end
      `CHK(seen, acc[i])
    end
    apb(0, LRC_ADDR_STATUS, 0, r); `CHK(r[2:0], 3'h7)
    apb(1, LRC_ADDR_CTRL1, 0, r);
    repeat (2) @(posedge clk);
    `CHK(receiverActive, 1'b0)
    `CHK(receiverReady, 1'b0)
    $display("id done");
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    numErrors++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_power();
    t_carrier();
    t_id();
    finish_test();
  end
endmodule
